// *** hw/flicker_gen.sv ***
// One flicker clock: drops low a set lead time before its channel pulse ends
`timescale 1ns/1ps
module flicker_gen #(
    parameter int CW = 16
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          active,
    input  wire logic [CW-1:0] remain,
    input  wire logic [CW-1:0] lead,
    output logic               flk_out
);
    always_ff @(posedge clock) begin
        if (rst) begin
            flk_out <= 1'b0;
        end else if (active && remain > lead) begin
            flk_out <= 1'b1;
        end else begin
            // Falls inside the final part of the pulse, so the device accepts it
            flk_out <= 1'b0;
        end
    end
endmodule : flicker_gen

// *** hw/gate_shift_ctrl.sv ***
// Timing controller that drives the channel inputs and flicker clocks of the level shifter
// Operation
// - Single flicker clock: drive flicker input a, hold b and c low.
// - Three flicker clocks: a serves 1 and 4, b 2 and 5, c 3 and 6.
// - Four-phase with three flicker clocks: phases 1,3 on flicker a, 2,4 on b, c held low.
// - Four-phase: unused channel 3 and 6 inputs held high.
// - Unused flicker inputs are held low by the controller; unused four-phase channel inputs are held high.
`timescale 1ns/1ps
`include "gate_shift_map.svh"
module gate_shift_ctrl #(
    parameter int CW = 16
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          run,
    input  wire logic          four_phase,
    input  wire logic          multi_flicker,
    input  wire logic          shaping_en,
    input  wire logic [CW-1:0] pulse_cycles,
    input  wire logic [CW-1:0] flk_lead_cycles,
    input  wire logic [2:0]    plain_level,
    output logic [5:0]         chan_in,
    output logic [2:0]         plain_in,
    output logic               flicker_clock_a,
    output logic               flicker_clock_b,
    output logic               flicker_clock_c,
    output logic               busy
);
    // Refuse counter widths the phase and lead arithmetic cannot serve
    if (CW < 4 || CW > 32) begin : g_bad_cw
        $error("gate_shift_ctrl: CW out of range");
    end

    gate_shift_pkg::seq_state_e state_reg;
    gate_shift_pkg::seq_state_e state_next;
    logic [CW-1:0]              cnt_reg;
    logic [CW-1:0]              cnt_next;
    logic [2:0]                 phase_reg;
    logic [2:0]                 phase_next;
    logic [2:0]                 last_phase;
    logic                       in_pulse;
    logic                       pulse_end;
    logic [CW-1:0]              remain;
    logic [CW-1:0]              window_len;
    logic [CW-1:0]              lead_eff;
    logic [5:0]                 chan_next;
    logic [2:0]                 flk_raw;
    logic [2:0]                 flk_act;

    // Four-phase uses slots 1,2,4,5 only
    assign last_phase = four_phase ? 3'h4 : 3'h5;
    assign in_pulse   = (state_reg == gate_shift_pkg::ST_PULSE);
    assign busy       = (state_reg != gate_shift_pkg::ST_IDLE);
    assign pulse_end  = in_pulse && (cnt_reg + CW'(1) >= pulse_cycles);
    assign remain     = pulse_cycles - cnt_reg;

    // Valid window: last sixth of the pulse in six-phase, last quarter in four-phase
    assign window_len = four_phase ? pulse_cycles / CW'(`GS_WIN_DIV_FOUR)
                                   : pulse_cycles / CW'(`GS_WIN_DIV_SIX);

    always_comb begin
        lead_eff = flk_lead_cycles;
        if (lead_eff > window_len) begin
            lead_eff = window_len;
        end
        if (lead_eff == '0) begin
            // A zero lead would drop the flicker with the channel, too late to count
            lead_eff = CW'(1);
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            gate_shift_pkg::ST_IDLE: begin
                if (run) begin
                    state_next = gate_shift_pkg::ST_PULSE;
                end
            end
            gate_shift_pkg::ST_PULSE: begin
                if (pulse_end) begin
                    state_next = gate_shift_pkg::ST_GAP;
                end
            end
            gate_shift_pkg::ST_GAP: begin
                // One idle cycle lets the fall of one phase precede the next rise
                if (phase_reg != last_phase || run) begin
                    state_next = gate_shift_pkg::ST_PULSE;
                end else begin
                    state_next = gate_shift_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = gate_shift_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        phase_next = phase_reg;
        case (state_reg)
            gate_shift_pkg::ST_IDLE: begin
                phase_next = 3'h0;
            end
            gate_shift_pkg::ST_PULSE: begin
                phase_next = phase_reg;
            end
            gate_shift_pkg::ST_GAP: begin
                if (phase_reg == last_phase) begin
                    phase_next = 3'h0;
                end else if (four_phase && phase_reg == 3'h1) begin
                    phase_next = 3'h3;
                end else begin
                    phase_next = phase_reg + 3'h1;
                end
            end
            default: begin
                phase_next = 3'h0;
            end
        endcase
    end

    always_comb begin
        if (in_pulse && !pulse_end) begin
            cnt_next = cnt_reg + CW'(1);
        end else begin
            cnt_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= gate_shift_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phase_reg <= 3'h0;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Shaping channel inputs; the device reads its windows from their timing alone
    generate
        for (genvar ch = 0; ch < `GS_SHAPE_CHANNELS; ch++) begin : g_chan
            always_comb begin
                if (four_phase && (ch % 3 == 2)) begin
                    chan_next[ch] = 1'b1;
                end else begin
                    chan_next[ch] = in_pulse && (phase_reg == 3'(ch));
                end
            end
            always_ff @(posedge clock) begin
                if (rst) begin
                    chan_in[ch] <= 1'b0;
                end else begin
                    chan_in[ch] <= chan_next[ch];
                end
            end
        end
    endgenerate

    generate
        for (genvar p = 0; p < `GS_PLAIN_CHANNELS; p++) begin : g_plain
            always_ff @(posedge clock) begin
                if (rst) begin
                    plain_in[p] <= 1'b0;
                end else begin
                    plain_in[p] <= plain_level[p];
                end
            end
        end
    endgenerate

    // Per flicker input, active while shaping_en is set and its channel pair is pulsing; in single-flicker mode a takes every channel
    generate
        for (genvar g = 0; g < `GS_FLICKER_INPUTS; g++) begin : g_flk
            always_comb begin
                if (!shaping_en) begin
                    flk_act[g] = 1'b0;
                end else if (!multi_flicker) begin
                    flk_act[g] = (g == 0) && in_pulse;
                end else if (four_phase && g == 2) begin
                    flk_act[g] = 1'b0;
                end else begin
                    flk_act[g] = in_pulse
                                 && (phase_reg == 3'(g) || phase_reg == 3'(g + 3));
                end
            end
            flicker_gen #(
                .CW (CW)
            ) flicker_gen_i (
                .clock   (clock),
                .rst     (rst),
                .active  (flk_act[g]),
                .remain  (remain),
                .lead    (lead_eff),
                .flk_out (flk_raw[g])
            );
        end
    endgenerate

    assign flicker_clock_a = flk_raw[0];
    assign flicker_clock_b = flk_raw[1];
    assign flicker_clock_c = flk_raw[2];
endmodule : gate_shift_ctrl

// *** hw/gate_shift_map.svh ***
// Constants for the gate-shaping level shifter timing controller
`ifndef GATE_SHIFT_MAP_SVH
`define GATE_SHIFT_MAP_SVH
`define GS_SHAPE_CHANNELS   6
`define GS_PLAIN_CHANNELS   3
`define GS_FLICKER_INPUTS   3
`define GS_PHASE_SIX        1'b0
`define GS_PHASE_FOUR       1'b1
`define GS_FLK_SINGLE       2'h0
`define GS_FLK_MULTI        2'h1
`define GS_DEF_PULSE_CYC    16'h0030
`define GS_DEF_FLK_LEAD_CYC 16'h0004
`define GS_WIN_DIV_SIX      16'h0006
`define GS_WIN_DIV_FOUR     16'h0004
`endif

// *** hw/gate_shift_pkg.sv ***
// Types for the gate-shaping level shifter timing controller
package gate_shift_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PULSE = 3'b010,
        ST_GAP   = 3'b100
    } seq_state_e;
endpackage : gate_shift_pkg

// *** tb/gate_shift_ctrl_properties.sv ***
// Checker on the flicker and channel outputs of the timing controller
`timescale 1ns/1ps
module gate_shift_ctrl_properties (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       four_phase,
    input wire logic       multi_flicker,
    input wire logic       shaping_en,
    input wire logic       busy,
    input wire logic [5:0] chan_in,
    input wire logic       flicker_clock_a,
    input wire logic       flicker_clock_b,
    input wire logic       flicker_clock_c
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_SINGLE_BC:
    assert property (!multi_flicker |-> !flicker_clock_b && !flicker_clock_c) else $error("b/c");
    AST_PAIR_B:
    assert property (multi_flicker && flicker_clock_b |-> chan_in[1] || chan_in[4]) else $error("b");
    AST_PAIR_C:
    assert property (flicker_clock_c |-> chan_in[2] || chan_in[5]) else $error("c");
    AST_FOUR_C:
    assert property (four_phase |-> !flicker_clock_c) else $error("c in four");
    AST_FOUR_HI:
    assert property ((four_phase && busy) [*3] |-> chan_in[2] && chan_in[5]) else $error("3/6");
    AST_OFF:
    assert property (!shaping_en [*2] |-> !(flicker_clock_a || flicker_clock_b || flicker_clock_c))
        else $error("flicker with shaping off");
    cover property (multi_flicker && flicker_clock_c);
    cover property (four_phase && flicker_clock_b);
    cover property ($fell(flicker_clock_a) && !multi_flicker);
endmodule : gate_shift_ctrl_properties
bind gate_shift_ctrl gate_shift_ctrl_properties gate_shift_ctrl_properties_i (
    .clock           (clock),
    .rst             (rst),
    .four_phase      (four_phase),
    .multi_flicker   (multi_flicker),
    .shaping_en      (shaping_en),
    .busy            (busy),
    .chan_in         (chan_in),
    .flicker_clock_a (flicker_clock_a),
    .flicker_clock_b (flicker_clock_b),
    .flicker_clock_c (flicker_clock_c)
);

// *** tb/level_shift_model.sv ***
// Behavioural shaping level shifter seen from its logic pins
`timescale 1ns/1ps
module level_shift_model (
    input  wire logic       clock,
    input  wire logic [5:0] chan_in,
    input  wire logic [2:0] plain_in,
    input  wire logic [2:0] flk,
    input  wire logic       four_phase,
    input  wire logic       multi_flicker,
    input  wire logic       supply_monitor_level,
    input  wire logic       clr,
    output logic [5:0]      shaped,
    output logic [2:0]      plain_out,
    output logic            discharge_out
);
    logic [5:0] chan_d;
    logic [2:0] flk_d;
    int         sel;
    int         cnt [6];
    int         wid [6];
    assign plain_out     = plain_in;
    assign discharge_out = !supply_monitor_level;
    // Window from the last pulse width, so no sync pin; first pulse takes any fall
    always @(posedge clock) begin
        chan_d <= chan_in;
        flk_d  <= flk;
        if (clr) shaped <= 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (!chan_in[i] && chan_d[i]) wid[i] = cnt[i];
            cnt[i] = chan_in[i] ? cnt[i] + 1 : 0;
            sel = multi_flicker ? i % 3 : 0;
            // Unused four-phase slots sit high and must never shape
            if (flk_d[sel] && !flk[sel] && chan_in[i] && supply_monitor_level
                && !(four_phase && i % 3 == 2)
                && (four_phase ? cnt[i] * 4 >= wid[i] * 3
                               : cnt[i] * 6 >= wid[i] * 5)) begin
                shaped[i] <= 1'b1;
            end
        end
    end
endmodule : level_shift_model

// *** tb/test_gate_shift_ctrl.sv ***
// Bench for the timing controller driving a level shifter model
`timescale 1ns/1ps
module test_gate_shift_ctrl;
    logic        clock = 1'b0, rst = 1'b1, run = 1'b0, clr = 1'b0;
    logic        four_phase = 1'b0, multi_flicker = 1'b0, shaping_en = 1'b1;
    logic        supply_monitor_level = 1'b1;
    logic [15:0] pulse_cycles = 16'h000C, flk_lead_cycles = 16'h0001;
    logic [2:0]  plain_level = 3'h0, plain_in, plain_out, flk;
    logic [5:0]  chan_in, shaped;
    logic        flicker_clock_a, flicker_clock_b, flicker_clock_c, busy, discharge_out;
    int          n_fail = 0, tests_run = 0, cyc = 0;
    assign flk = {flicker_clock_c, flicker_clock_b, flicker_clock_a};
    always #25 clock = !clock;
    gate_shift_ctrl #(
        .CW (16)
    ) gate_shift_ctrl_i (
        .clock           (clock),
        .rst             (rst),
        .run             (run),
        .four_phase      (four_phase),
        .multi_flicker   (multi_flicker),
        .shaping_en      (shaping_en),
        .pulse_cycles    (pulse_cycles),
        .flk_lead_cycles (flk_lead_cycles),
        .plain_level     (plain_level),
        .chan_in         (chan_in),
        .plain_in        (plain_in),
        .flicker_clock_a (flicker_clock_a),
        .flicker_clock_b (flicker_clock_b),
        .flicker_clock_c (flicker_clock_c),
        .busy            (busy)
    );
    level_shift_model level_shift_model_i (
        .clock                (clock),
        .chan_in              (chan_in),
        .plain_in             (plain_in),
        .flk                  (flk),
        .four_phase           (four_phase),
        .multi_flicker        (multi_flicker),
        .supply_monitor_level (supply_monitor_level),
        .clr                  (clr),
        .shaped               (shaped),
        .plain_out            (plain_out),
        .discharge_out        (discharge_out)
    );
    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    // Two frames: the first only teaches the model the pulse width
    task automatic frames();
        repeat (2) begin
            clr <= 1'b1;
            run <= 1'b1;
            repeat (3) @(posedge clock);
            clr <= 1'b0;
            run <= 1'b0;
            do @(posedge clock); while (busy !== 1'b0);
        end
    endtask : frames
    task automatic six_single();
        frames();
        check(shaped, 6'h3F);
    endtask : six_single
    task automatic six_multi();
        multi_flicker <= 1'b1;
        frames();
        check(shaped, 6'h3F);
    endtask : six_multi
    task automatic four_pair();
        four_phase <= 1'b1;
        flk_lead_cycles <= 16'h0002;
        frames();
        check(shaped, 6'h1B);
        four_phase <= 1'b0;
    endtask : four_pair
    // Supply sense low: no shaping anywhere, discharge output raised
    task automatic power_down();
        check({5'h00, discharge_out}, 6'h00);
        supply_monitor_level <= 1'b0;
        frames();
        check(shaped, 6'h00);
        check({5'h00, discharge_out}, 6'h01);
        supply_monitor_level <= 1'b1;
    endtask : power_down
    task automatic quiet();
        shaping_en <= 1'b0;
        plain_level <= 3'h5;
        frames();
        check(shaped, 6'h00);
        check({3'h0, plain_out}, 6'h05);
    endtask : quiet
    task automatic tally_and_finish();
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        six_single();
        six_multi();
        four_pair();
        power_down();
        quiet();
        tally_and_finish();
    end
endmodule : test_gate_shift_ctrl
